// ==== bmc_blit_ctl.sv ====
// mono source control and upper blit control: registers, status, pattern and source expansion
// assumes single-cycle memory-space accesses on mclk; read data follows one cycle later
`timescale 1ns/100ps
`default_nettype none
module bmc_blit_ctl
  import bmc_pkg::*;
(
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     nrst,
  // memory-space register access
  input  wire logic [23:0]              mem_addr,
  input  wire logic                     mem_wr,
  input  wire logic                     mem_rd,
  input  wire logic [3:0]               mem_be,
  input  wire logic [31:0]              mem_wdata,
  output logic      [31:0]              mem_rdata,
  output logic                          mem_hit,
  // engine sequencing
  input  wire logic                     blit_start,
  input  wire logic                     dst_last_done,
  input  wire logic                     dst_line_end,
  input  wire logic [11:0]              dst_addr_lo,
  input  wire logic [11:0]              line_bits,
  input  wire logic [11:0]              line_count,
  input  wire bmc_pkg::bmc_depth_e      cfg_depth,
  output logic                          blit_busy,
  output logic                          src_is_mono,
  output logic                          pat_is_mono,
  output logic [bmc_pkg::BMC_LOW_CTL_W-1:0] blt_low_ctl,
  // expansion colours
  input  wire logic [23:0]              shared_expand_background_color,
  input  wire logic [23:0]              shared_expand_foreground_color,
  input  wire logic [23:0]              source_expand_background_color,
  input  wire logic [23:0]              source_expand_foreground_color,
  // mono source quadwords
  input  wire logic [63:0]              src_qw_data,
  input  wire logic                     src_qw_valid,
  output logic                          src_qw_ready,
  // expanded mono source pixels
  output logic [23:0]                   src_px_color,
  output logic                          src_px_valid,
  output logic                          src_px_eol,
  input  wire logic                     src_px_ready,
  // pattern
  input  wire logic                     pat_bit,
  output logic                          pat_fetch_en,
  output logic [2:0]                    pat_row,
  output logic [2:0]                    pat_hidx,
  output logic [23:0]                   pat_color
);
  typedef struct packed {
    logic [31:0] msc;
    logic [31:0] bctl;
    logic        busy;
    logic [2:0]  row;
    logic [2:0]  hidx;
    logic [23:0] px_color;
    logic        px_valid;
    logic        px_eol;
    logic [23:0] pat_color;
    logic [31:0] rdata;
  } bmc_ctl_s;

  bmc_ctl_s    s_r;
  bmc_ctl_s    s_nxt;
  bmc_seq_if   sif ();

  logic        hit_msc;
  logic        hit_bctl;
  logic [31:0] be_mask;
  logic        src_mono;
  logic        pat_mono;
  logic        solid;
  logic        start_ok;
  logic [11:0] px24;
  logic        exp_bit   [2];
  logic [23:0] exp_bg    [2];
  logic [23:0] exp_fg    [2];
  logic [23:0] exp_color [2];

  assign hit_msc  = ((mem_addr & BMC_ALIAS_MASK) == BMC_MONO_SRC_CTL_OFS);
  assign hit_bctl = ((mem_addr & BMC_ALIAS_MASK) == BMC_BLIT_CTL_OFS);
  assign mem_hit  = hit_msc || hit_bctl;
  assign be_mask  = {{8{mem_be[3]}}, {8{mem_be[2]}}, {8{mem_be[1]}}, {8{mem_be[0]}}};

  assign src_mono = s_r.bctl[BMC_SRC_DEPTH_BIT];
  assign pat_mono = s_r.bctl[BMC_PAT_DEPTH_BIT];
  assign solid    = s_r.bctl[BMC_SOLID_PAT_BIT] && pat_mono;
  assign start_ok = blit_start && !s_r.busy;

  // sequencer link
  assign sif.start     = start_ok && src_mono;
  assign sif.align     = s_r.msc[BMC_ALIGN_LSB +: 3];
  assign sif.discard   = s_r.msc[BMC_DISCARD_LSB +: 6];
  assign sif.lclip     = s_r.msc[BMC_LCLIP_LSB +: 6];
  assign sif.rclip     = s_r.msc[BMC_RCLIP_LSB +: 6];
  assign sif.line_bits = line_bits;
  assign sif.lines     = line_count;
  assign sif.qw_data   = src_qw_data;
  assign sif.qw_valid  = src_qw_valid && src_mono;
  assign sif.bit_ready = !s_r.px_valid || src_px_ready;
  assign src_qw_ready  = sif.qw_ready && src_mono;

  bmc_mono_seq u_seq (
    .mclk (mclk),
    .nrst (nrst),
    .sif  (sif.seq)
  );

  // expander 0 serves the mono source, expander 1 the pattern
  assign exp_bit[0] = sif.bit_val;
  assign exp_bg[0]  = s_r.msc[BMC_SRC_EXP_SEL_BIT] ? source_expand_background_color
                                                   : shared_expand_background_color;
  assign exp_fg[0]  = s_r.msc[BMC_SRC_EXP_SEL_BIT] ? source_expand_foreground_color
                                                   : shared_expand_foreground_color;
  assign exp_bit[1] = solid ? 1'b0 : pat_bit;
  assign exp_bg[1]  = shared_expand_background_color;
  assign exp_fg[1]  = shared_expand_foreground_color;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_exp
      bmc_expand u_exp (
        .bit_in (exp_bit[g]),
        .bg     (exp_bg[g]),
        .fg     (exp_fg[g]),
        .depth  (cfg_depth),
        .color  (exp_color[g])
      );
    end
  endgenerate

  // 24 bpp pixels are three bytes wide, so the column needs a divide
  assign px24 = dst_addr_lo / 12'h003;

  always_comb begin
    s_nxt = s_r;
    // register writes, status bit excluded by the mask
    if (mem_wr && hit_msc) begin
      s_nxt.msc = ((s_r.msc & ~be_mask) | (mem_wdata & be_mask)) & BMC_MONO_SRC_WMASK;
    end
    if (mem_wr && hit_bctl) begin
      s_nxt.bctl = ((s_r.bctl & ~be_mask) | (mem_wdata & be_mask)) & BMC_BLIT_WMASK;
    end
    // read data
    if (mem_rd) begin
      if (hit_msc) begin
        s_nxt.rdata = s_r.msc & BMC_MONO_SRC_WMASK;
      end else if (hit_bctl) begin
        s_nxt.rdata = (s_r.bctl & BMC_BLIT_WMASK) | ({31'h0, s_r.busy} << BMC_STATUS_BIT);
      end else begin
        s_nxt.rdata = 32'h00000000;
      end
    end
    // engine status; a start while busy is ignored
    if (start_ok) begin
      s_nxt.busy = 1'b1;
    end else if (dst_last_done) begin
      s_nxt.busy = 1'b0;
    end
    // pattern row: loaded at start, steps once per destination line
    if (start_ok) begin
      s_nxt.row = s_r.bctl[BMC_PAT_VALIGN_LSB +: 3];
    end else if (dst_line_end) begin
      s_nxt.row = s_r.row + 3'h1;
    end
    case (cfg_depth)
      BMC_DEP_8:  s_nxt.hidx = dst_addr_lo[2:0];
      BMC_DEP_16: s_nxt.hidx = dst_addr_lo[3:1];
      default:    s_nxt.hidx = px24[2:0];
    endcase
    s_nxt.pat_color = exp_color[1];
    // mono source pixel output register
    if (sif.bit_valid && sif.bit_ready) begin
      s_nxt.px_color = exp_color[0];
      s_nxt.px_valid = 1'b1;
      s_nxt.px_eol   = sif.bit_eol;
    end else if (src_px_ready) begin
      s_nxt.px_valid = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_r      <= '0;
      s_r.msc  <= BMC_MONO_SRC_RST;
      s_r.bctl <= BMC_BLIT_RST;
      s_r.row  <= BMC_PAT_ROW_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mem_rdata    = s_r.rdata;
  assign blit_busy    = s_r.busy;
  assign src_is_mono  = src_mono;
  assign pat_is_mono  = pat_mono;
  assign blt_low_ctl  = s_r.bctl[BMC_LOW_CTL_W-1:0];
  assign src_px_color = s_r.px_color;
  assign src_px_valid = s_r.px_valid;
  assign src_px_eol   = s_r.px_eol;
  assign pat_fetch_en = !solid;
  assign pat_row      = s_r.row;
  assign pat_hidx     = s_r.hidx;
  assign pat_color    = s_r.pat_color;
endmodule : bmc_blit_ctl
`default_nettype wire

// ==== bmc_pkg.sv ====
// constants and types shared by the monochrome source and blit control block
// assumes one 125 MHz clock (mclk) and an asynchronous active-low reset (nrst)
package bmc_pkg;
  // memory-space offsets; bit 23 selects the alias window and is ignored
  localparam logic [23:0] BMC_MONO_SRC_CTL_OFS = 24'h40000C;
  localparam logic [23:0] BMC_BLIT_CTL_OFS     = 24'h400010;
  localparam logic [23:0] BMC_ALIAS_MASK       = 24'h7FFFFF;

  // writable bits; everything else reads zero, except the blit control status bit, which reads busy
  localparam logic [31:0] BMC_MONO_SRC_WMASK   = 32'h0F3F3F3F;
  localparam logic [31:0] BMC_BLIT_WMASK       = 32'h007FF7FF;
  localparam logic [31:0] BMC_MONO_SRC_RST     = 32'h00000000;
  localparam logic [31:0] BMC_BLIT_RST         = 32'h00000000;

  // mono source control fields
  localparam int BMC_SRC_EXP_SEL_BIT = 27;
  localparam int BMC_ALIGN_LSB       = 24;
  localparam int BMC_DISCARD_LSB     = 16;
  localparam int BMC_RCLIP_LSB       = 8;
  localparam int BMC_LCLIP_LSB       = 0;

  // blit control fields
  localparam int BMC_STATUS_BIT      = 31;
  localparam int BMC_PAT_VALIGN_LSB  = 20;
  localparam int BMC_SOLID_PAT_BIT   = 19;
  localparam int BMC_PAT_DEPTH_BIT   = 18;
  localparam int BMC_SRC_DEPTH_BIT   = 12;
  localparam int BMC_LOW_CTL_W       = 18;

  localparam logic [2:0] BMC_PAT_ROW_RST = 3'h0;

  typedef enum logic [2:0] {
    BMC_ALN_BIT   = 3'h1,
    BMC_ALN_BYTE  = 3'h2,
    BMC_ALN_WORD  = 3'h3,
    BMC_ALN_DWORD = 3'h4,
    BMC_ALN_QWORD = 3'h5
  } bmc_align_e;

  // engine colour depth from the blit configuration
  typedef enum logic [1:0] {
    BMC_DEP_8  = 2'h0,
    BMC_DEP_16 = 2'h1,
    BMC_DEP_24 = 2'h2
  } bmc_depth_e;

  typedef enum logic [5:0] {
    BMC_SQ_IDLE    = 6'h01,
    BMC_SQ_DISCARD = 6'h02,
    BMC_SQ_LCLIP   = 6'h04,
    BMC_SQ_DATA    = 6'h08,
    BMC_SQ_RCLIP   = 6'h10,
    BMC_SQ_ALIGN   = 6'h20
  } bmc_seq_state_e;
endpackage : bmc_pkg

// ==== bmc_seq_if.sv ====
// interface between the control top and the mono source sequencer
// assumes both ends run on mclk
`timescale 1ns/100ps
`default_nettype none
interface bmc_seq_if;
  import bmc_pkg::*;
  logic        start;
  logic [2:0]  align;
  logic [5:0]  discard;
  logic [5:0]  lclip;
  logic [5:0]  rclip;
  logic [11:0] line_bits;
  logic [11:0] lines;
  logic [63:0] qw_data;
  logic        qw_valid;
  logic        qw_ready;
  logic        bit_val;
  logic        bit_valid;
  logic        bit_ready;
  logic        bit_eol;
  logic        active;

  modport seq (input start, align, discard, lclip, rclip, line_bits, lines, qw_data, qw_valid,
               bit_ready, output qw_ready, bit_val, bit_valid, bit_eol, active);
  modport ctl (output start, align, discard, lclip, rclip, line_bits, lines, qw_data, qw_valid,
               bit_ready, input qw_ready, bit_val, bit_valid, bit_eol, active);
endinterface : bmc_seq_if
`default_nettype wire

// ==== bmc_expand.sv ====
// monochrome to colour expansion of one bit
// assumes colours and depth are stable while used; purely combinational
`timescale 1ns/100ps
`default_nettype none
module bmc_expand
  import bmc_pkg::*;
(
  // mono bit and colour pair
  input  wire logic        bit_in,
  input  wire logic [23:0] bg,
  input  wire logic [23:0] fg,
  input  wire bmc_depth_e  depth,
  // expanded colour
  output logic      [23:0] color
);
  logic [23:0] raw;

  always_comb begin
    raw = bit_in ? fg : bg;
    case (depth)
      BMC_DEP_8:  color = {16'h0000, raw[7:0]};
      BMC_DEP_16: color = {8'h00, raw[15:0]};
      default:    color = raw;
    endcase
  end
endmodule : bmc_expand
`default_nettype wire

// ==== bmc_mono_seq.sv ====
// mono source bit sequencer: initial discard, per-line clipping, scan-line alignment
// assumes quadwords arrive with valid/ready; bit order is byte 0 first, msb first in a byte
`timescale 1ns/100ps
`default_nettype none
module bmc_mono_seq
  import bmc_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // link to control top
  bmc_seq_if.seq    sif
);
  typedef struct packed {
    bmc_seq_state_e st;
    logic [63:0]    qw;
    logic           have;
    logic [5:0]     ptr;
    logic [11:0]    cnt;
    logic [11:0]    lines;
    logic           bval;
    logic           bvalid;
    logic           beol;
  } bmc_seq_s;

  bmc_seq_s   s_r;
  bmc_seq_s   s_nxt;
  logic [5:0] amask;
  logic       cur;
  logic       slot_free;

  assign sif.qw_ready  = !s_r.have;
  assign sif.bit_val   = s_r.bval;
  assign sif.bit_valid = s_r.bvalid;
  assign sif.bit_eol   = s_r.beol;
  assign sif.active    = (s_r.st != BMC_SQ_IDLE);

  always_comb begin
    // reserved codes behave as bit alignment: no padding is skipped
    case (sif.align)
      BMC_ALN_BYTE:  amask = 6'h07;
      BMC_ALN_WORD:  amask = 6'h0F;
      BMC_ALN_DWORD: amask = 6'h1F;
      BMC_ALN_QWORD: amask = 6'h3F;
      default:       amask = 6'h00;
    endcase
  end

  assign cur       = s_r.qw[{s_r.ptr[5:3], ~s_r.ptr[2:0]}];
  assign slot_free = !s_r.bvalid || sif.bit_ready;

  always_comb begin
    s_nxt = s_r;
    if (s_r.bvalid && sif.bit_ready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (!s_r.have && sif.qw_valid) begin
      s_nxt.qw   = sif.qw_data;
      s_nxt.have = 1'b1;
      s_nxt.ptr  = 6'h00;
    end
    case (s_r.st)
      BMC_SQ_IDLE: begin
        // only started for mono source; colour source leaves this idle
        if (sif.start && (sif.lines != 12'h000)) begin
          s_nxt.st    = BMC_SQ_DISCARD;
          s_nxt.cnt   = {6'h00, sif.discard};
          s_nxt.lines = sif.lines;
          s_nxt.have  = 1'b0;
          s_nxt.ptr   = 6'h00;
        end
      end
      BMC_SQ_DISCARD: begin
        if (s_r.cnt == 12'h000) begin
          s_nxt.st  = BMC_SQ_LCLIP;
          s_nxt.cnt = {6'h00, sif.lclip};
        end else if (s_r.have) begin
          s_nxt.cnt = s_r.cnt - 12'h001;
        end
      end
      BMC_SQ_LCLIP: begin
        if (s_r.cnt == 12'h000) begin
          s_nxt.st  = BMC_SQ_DATA;
          s_nxt.cnt = sif.line_bits;
        end else if (s_r.have) begin
          s_nxt.cnt = s_r.cnt - 12'h001;
        end
      end
      BMC_SQ_DATA: begin
        if (s_r.cnt == 12'h000) begin
          s_nxt.st  = BMC_SQ_RCLIP;
          s_nxt.cnt = {6'h00, sif.rclip};
        end else if (s_r.have && slot_free) begin
          s_nxt.cnt    = s_r.cnt - 12'h001;
          s_nxt.bval   = cur;
          s_nxt.bvalid = 1'b1;
          s_nxt.beol   = (s_r.cnt == 12'h001);
        end
      end
      BMC_SQ_RCLIP: begin
        if (s_r.cnt == 12'h000) begin
          s_nxt.st = BMC_SQ_ALIGN;
        end else if (s_r.have) begin
          s_nxt.cnt = s_r.cnt - 12'h001;
        end
      end
      BMC_SQ_ALIGN: begin
        if ((s_r.ptr & amask) == 6'h00) begin
          s_nxt.lines = s_r.lines - 12'h001;
          s_nxt.cnt   = {6'h00, sif.lclip};
          s_nxt.st    = (s_r.lines == 12'h001) ? BMC_SQ_IDLE : BMC_SQ_LCLIP;
        end
      end
      default: s_nxt.st = BMC_SQ_IDLE;
    endcase
    // one source bit is used up by every counting or padding step
    if (s_r.have && (s_r.st != BMC_SQ_IDLE)
        && (((s_r.st == BMC_SQ_ALIGN) && ((s_r.ptr & amask) != 6'h00))
         || ((s_r.st != BMC_SQ_ALIGN) && (s_r.cnt != 12'h000)
             && ((s_r.st != BMC_SQ_DATA) || slot_free)))) begin
      s_nxt.ptr = s_r.ptr + 6'h01;
      if (s_r.ptr == 6'h3F) begin
        s_nxt.have = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{st: BMC_SQ_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : bmc_mono_seq
`default_nettype wire

// ==== bmc_blit_ctl_asserts.sv ====
// port assertions for the blit control block
// assumes one mclk domain with async active-low nrst; bound into bmc_blit_ctl
`timescale 1ns/100ps
`default_nettype none
module bmc_blit_ctl_asserts
  import bmc_pkg::*;
(
  // clock and reset
  input wire logic               mclk,
  input wire logic               nrst,
  // register access
  input wire logic [23:0]        mem_addr,
  input wire logic               mem_rd,
  input wire logic [31:0]        mem_rdata,
  input wire logic               mem_hit,
  // engine and pattern
  input wire logic               blit_start,
  input wire logic               dst_last_done,
  input wire logic               dst_line_end,
  input wire logic [11:0]        dst_addr_lo,
  input wire bmc_pkg::bmc_depth_e cfg_depth,
  input wire logic               blit_busy,
  input wire logic               src_is_mono,
  input wire logic               pat_is_mono,
  input wire logic               src_qw_ready,
  input wire logic               pat_fetch_en,
  input wire logic [2:0]         pat_row,
  input wire logic [2:0]         pat_hidx
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  // address one cycle back, since $past cannot be sliced
  logic [11:0] addr_r;
  always_ff @(posedge mclk) addr_r <= dst_addr_lo;

  busy_set_a: assert property (!blit_busy && blit_start |=> blit_busy)
    else $error("status not set after start");
  busy_hold_a: assert property (blit_busy && !dst_last_done |=> blit_busy)
    else $error("status dropped before last write");
  busy_clear_a: assert property (blit_busy && dst_last_done |=> !blit_busy)
    else $error("status not cleared");
  idle_hold_a: assert property (!blit_busy && !blit_start |=> !blit_busy)
    else $error("status set without start");
  row_step_a: assert property (dst_line_end && !(blit_start && !blit_busy)
    |=> pat_row == $past(pat_row) + 3'h1)
    else $error("pattern row did not advance");
  hidx_byte_a: assert property (cfg_depth == BMC_DEP_8 |=> pat_hidx == addr_r[2:0])
    else $error("pattern index wrong at 8bpp");
  hidx_word_a: assert property (cfg_depth == BMC_DEP_16 |=> pat_hidx == addr_r[3:1])
    else $error("pattern index wrong at 16bpp");
  solid_mono_a: assert property (!pat_fetch_en |-> pat_is_mono)
    else $error("fetch suppressed for colour pattern");
  colour_src_a: assert property (!src_is_mono |-> !src_qw_ready)
    else $error("source taken while colour");
  unmapped_a: assert property (mem_rd && !mem_hit |=> mem_rdata == 32'h0)
    else $error("unmapped read not zero");
  mono_rsvd_a: assert property (mem_rd && mem_addr[22:0] == 23'h40000C
    |=> (mem_rdata & ~BMC_MONO_SRC_WMASK) == 32'h0)
    else $error("mono control reserved bits set");
  blit_rsvd_a: assert property (mem_rd && mem_addr[22:0] == 23'h400010
    |=> (mem_rdata & 32'h7F800800) == 32'h0 && mem_rdata[31] == $past(blit_busy))
    else $error("blit control read wrong");
endmodule : bmc_blit_ctl_asserts

bind bmc_blit_ctl bmc_blit_ctl_asserts bmc_blit_ctl_asserts_inst (.mclk, .nrst, .mem_addr,
  .mem_rd, .mem_rdata, .mem_hit, .blit_start, .dst_last_done, .dst_line_end, .dst_addr_lo,
  .cfg_depth, .blit_busy, .src_is_mono, .pat_is_mono, .src_qw_ready, .pat_fetch_en, .pat_row,
  .pat_hidx);
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for bmc_blit_ctl
// drives every port itself; the checker arrives by bind
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import bmc_pkg::*;
  logic        mclk = 1'b0, nrst = 1'b0, mem_wr = 1'b0, mem_rd = 1'b0, mem_hit;
  logic [23:0] mem_addr = 24'h0;
  logic [3:0]  mem_be = 4'hF;
  logic [31:0] mem_wdata = 32'h0, mem_rdata, rv;
  logic        blit_start = 1'b0, dst_last_done = 1'b0, dst_line_end = 1'b0;
  logic [11:0] dst_addr_lo = 12'h0, line_bits = 12'h4, line_count = 12'h1;
  bmc_depth_e  cfg_depth = BMC_DEP_24;
  logic        blit_busy, src_is_mono, pat_is_mono, src_qw_ready, src_px_valid, src_px_eol;
  logic [17:0] blt_low_ctl;
  logic [23:0] sh_bg = 24'hA5B6C7, sh_fg = 24'h123456, so_bg = 24'h0F1E2D, so_fg = 24'h5A6B7C;
  logic [63:0] src_qw_data = {48'h0, 8'hED, 8'h0B};
  logic        src_qw_valid = 1'b0, src_px_ready = 1'b0, pat_bit = 1'b0, pat_fetch_en;
  logic [23:0] src_px_color, pat_color;
  logic [2:0]  pat_row, pat_hidx;
  int          mismatches = 0, check_count = 0, cycles = 0;

  always #4 mclk = ~mclk;

  bmc_blit_ctl bmc_blit_ctl_inst (.mclk, .nrst, .mem_addr, .mem_wr, .mem_rd, .mem_be, .mem_wdata,
    .mem_rdata, .mem_hit, .blit_start, .dst_last_done, .dst_line_end, .dst_addr_lo, .line_bits,
    .line_count, .cfg_depth, .blit_busy, .src_is_mono, .pat_is_mono, .blt_low_ctl,
    .shared_expand_background_color(sh_bg), .shared_expand_foreground_color(sh_fg),
    .source_expand_background_color(so_bg), .source_expand_foreground_color(so_fg),
    .src_qw_data, .src_qw_valid, .src_qw_ready, .src_px_color, .src_px_valid, .src_px_eol,
    .src_px_ready, .pat_bit, .pat_fetch_en, .pat_row, .pat_hidx, .pat_color);

  task automatic end_of_test;
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [23:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk);
    mem_addr <= a;
    mem_wdata <= d;
    mem_be <= be;
    mem_wr <= 1'b1;
    @(posedge mclk);
    mem_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [23:0] a);
    @(posedge mclk);
    mem_addr <= a;
    mem_rd <= 1'b1;
    @(posedge mclk);
    mem_rd <= 1'b0;
    #1;
    rv = mem_rdata;
  endtask : rd

  // k: 0 start, 1 last write done, 2 line end
  task automatic pulse(input int k);
    @(posedge mclk);
    blit_start <= (k == 0);
    dst_last_done <= (k == 1);
    dst_line_end <= (k == 2);
    @(posedge mclk);
    {blit_start, dst_last_done, dst_line_end} <= 3'h0;
    #1;
  endtask : pulse

  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle

  task automatic test_regs;
    rd(BMC_BLIT_CTL_OFS);
    chk(rv, BMC_BLIT_RST);
    wr(BMC_MONO_SRC_CTL_OFS, 32'hFFFFFFFF, 4'hF);
    rd(BMC_MONO_SRC_CTL_OFS);
    chk(rv, 32'h0F3F3F3F);
    wr(BMC_MONO_SRC_CTL_OFS, 32'h0, 4'h2);
    rd(24'hC0000C);
    chk(rv, 32'h0F3F003F);
    chk(mem_hit, 1'b1);
    wr(BMC_BLIT_CTL_OFS, 32'hFFFFFFFF, 4'hF);
    rd(BMC_BLIT_CTL_OFS);
    chk(rv, 32'h007FF7FF);
    chk(blt_low_ctl, 32'h0003F7FF);
    chk(src_is_mono, 1'b1);
    chk(pat_is_mono, 1'b1);
    rd(24'h400014);
    chk(rv, 32'h0);
    chk(mem_hit, 1'b0);
  endtask : test_regs

  task automatic test_busy;
    wr(BMC_BLIT_CTL_OFS, 32'h0, 4'hF);
    pulse(0);
    chk(blit_busy, 1'b1);
    settle;
    chk(src_qw_ready, 1'b0);
    rd(BMC_BLIT_CTL_OFS);
    chk(rv, 32'h80000000);
    pulse(0);
    chk(blit_busy, 1'b1);
    pulse(1);
    chk(blit_busy, 1'b0);
  endtask : test_busy

  task automatic test_row;
    wr(BMC_BLIT_CTL_OFS, 32'h00500000, 4'hF);
    pulse(0);
    chk(pat_row, 3'h5);
    repeat (3) pulse(2);
    chk(pat_row, 3'h0);
    pulse(1);
  endtask : test_row

  task automatic test_pat;
    @(posedge mclk);
    cfg_depth <= BMC_DEP_16;
    pat_bit <= 1'b1;
    wr(BMC_BLIT_CTL_OFS, 32'h000C0000, 4'hF);
    settle;
    chk(pat_fetch_en, 1'b0);
    chk(pat_color, 24'h00B6C7);
    wr(BMC_BLIT_CTL_OFS, 32'h00080000, 4'hF);
    settle;
    chk(pat_fetch_en, 1'b1);
    wr(BMC_BLIT_CTL_OFS, 32'h00040000, 4'hF);
    settle;
    chk(pat_color, 24'h003456);
  endtask : test_pat

  task automatic test_hidx;
    logic [11:0] a [3] = '{12'h00D, 12'h00D, 12'h015};
    bmc_depth_e  d [3] = '{BMC_DEP_8, BMC_DEP_16, BMC_DEP_24};
    logic [2:0]  e [3] = '{3'h5, 3'h6, 3'h7};
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      cfg_depth <= d[i];
      dst_addr_lo <= a[i];
      settle;
      chk(pat_hidx, e[i]);
    end
  endtask : test_hidx

  // discard 3, right clip 2, left clip 1, two lines of four bits; byte alignment pads to bit 16
  task automatic test_mono(input logic sel, input bmc_depth_e dep, input logic [2:0] aln,
                           input logic [7:0] exp_in);
    logic [23:0] m, bg, fg;
    logic [7:0]  exp_bits;
    logic        took;
    int          n;
    m = (dep == BMC_DEP_8) ? 24'hFF : (dep == BMC_DEP_16) ? 24'hFFFF : 24'hFFFFFF;
    bg = (sel ? so_bg : sh_bg) & m;
    fg = (sel ? so_fg : sh_fg) & m;
    exp_bits = exp_in;
    took = 1'b0;
    n = 0;
    wr(BMC_MONO_SRC_CTL_OFS, {4'h0, sel, aln, 24'h030201}, 4'hF);
    wr(BMC_BLIT_CTL_OFS, 32'h00001000, 4'hF);
    @(posedge mclk);
    cfg_depth <= dep;
    line_count <= 12'h2;
    pulse(0);
    // px_ready toggles so the output side stalls every other cycle
    for (int c = 0; c < 200; c++) begin
      @(posedge mclk);
      src_px_ready <= c[0];
      src_qw_valid <= !took;
      #1;
      if (src_qw_valid && src_qw_ready) took = 1'b1;
      if (src_px_valid && src_px_ready) begin
        if (n < 8) begin
          chk(src_px_color, exp_bits[7-n] ? fg : bg);
          chk(src_px_eol, (n == 3) || (n == 7));
        end
        n++;
      end
    end
    chk(n, 8);
    pulse(1);
  endtask : test_mono

  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    test_regs;
    test_busy;
    test_row;
    test_pat;
    test_hidx;
    test_mono(1'b1, BMC_DEP_24, BMC_ALN_BIT, 8'hB6);
    test_mono(1'b0, BMC_DEP_8, BMC_ALN_BIT, 8'hB6);
    test_mono(1'b0, BMC_DEP_16, BMC_ALN_BYTE, 8'hB0);
    end_of_test;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test;
    end
  end
endmodule : testbench
`default_nettype wire
